// File: design/dwt_top.sv
// dual 16-bit multimode timer with a classic wishbone register slave
// Functional notes
// - timers count down; the pulse after zero underflows, reloads from latch, continues.
// - each underflow sets that timer's request bit.
// - timer mode counts main oscillator over 16, or sub oscillator over 16 when selected.
// - timer a pulse output mode toggles its pin at every underflow.
// - timer a event counter mode counts edges on its pin.
// - timer a pulse width mode counts while pin high (edge 0) or low (1).
// - write control 0: writes load counter and latch together.
// - write control 1: writes load only latch; counter takes it at underflow.
// - timer a pin request follows its active edge selection.
// - period mode: selected b pin edge requests, reloads counter, continues.
// - count before an edge reload is held until timer b is read once.
// - timer b event counter mode counts edges on its pin.
// - high/low mode: both b pin edges request and reload.
// - each timer underflow is its own request source.
// - other b modes: b pin request follows its active edge selection.
// - software clears request bits by writing zero; writing one does nothing.
`timescale 1ns/1ps
`default_nettype none
module dwt_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dwt_pkg::dwt_wb_req_s wb_req_i,
  output dwt_pkg::dwt_wb_rsp_s wb_rsp_o,
  input wire logic main_osc_input_i,
  input wire logic sub_osc_input_i,
  input wire logic wide_timer_a_pin_i,
  output logic wide_timer_a_pin_o,
  output logic wide_timer_a_pin_oe_n_o,
  input wire logic wide_timer_b_pin_i,
  output logic [dwt_pkg::DWT_IRQ_N-1:0] irq_req_o
);
  import dwt_pkg::*;

  typedef struct packed {
    logic [DWT_SY_N-1:0] sy1;
    logic [DWT_SY_N-1:0] sy2;
    logic [DWT_SY_N-1:0] prev;
    logic [DWT_PRE_W-1:0] pre;
    logic [DWT_BYTE_W-1:0] mode_a;
    logic [DWT_BYTE_W-1:0] mode_b;
    logic sys_sub;
    logic [DWT_IRQ_N-1:0] ireq;
    logic pulse;
    logic ack;
    logic [31:0] dat;
  } dwt_top_s;

  // edge chosen by an active edge bit: 0 rising, 1 falling
  function automatic logic dwt_sel_edge(input logic cur, input logic prv, input logic fall);
    dwt_sel_edge = fall ? (prv & ~cur) : (cur & ~prv);
  endfunction : dwt_sel_edge

  function automatic logic dwt_any_edge(input logic cur, input logic prv);
    dwt_any_edge = cur ^ prv;
  endfunction : dwt_any_edge

  dwt_top_s st_r;
  dwt_top_s st_nxt;
  dwt_byte_acc_s acc_a;
  dwt_byte_acc_s acc_b;
  logic tick_a;
  logic tick_b;
  logic reload_b;
  logic uf_a;
  logic uf_b;
  logic [DWT_BYTE_W-1:0] a_hi;
  logic [DWT_BYTE_W-1:0] a_lo;
  logic [DWT_BYTE_W-1:0] b_hi;
  logic [DWT_BYTE_W-1:0] b_lo;

  // decoded values used by the datapath
  logic req;
  logic wr;
  logic rd;
  logic osc_edge;
  logic tick16;
  logic pin_a;
  logic pin_b;
  logic edge_a;
  logic edge_b;
  logic both_b;
  logic fall_a;
  logic fall_b;
  dwt_mode_e mode_a;
  dwt_mode_e mode_b;

  always_comb begin
    req = wb_req_i.cyc & wb_req_i.stb & ~st_r.ack;
    wr = req & wb_req_i.we & wb_req_i.sel[0];
    rd = req & ~wb_req_i.we;
    mode_a = dwt_mode_e'(st_r.mode_a[DWT_MODE_LSB +: 2]);
    mode_b = dwt_mode_e'(st_r.mode_b[DWT_MODE_LSB +: 2]);
    fall_a = st_r.mode_a[DWT_EDGE_BIT];
    fall_b = st_r.mode_b[DWT_EDGE_BIT];
    pin_a = st_r.sy2[DWT_SY_PIN_A];
    pin_b = st_r.sy2[DWT_SY_PIN_B];
    edge_a = dwt_sel_edge(pin_a, st_r.prev[DWT_SY_PIN_A], fall_a);
    edge_b = dwt_sel_edge(pin_b, st_r.prev[DWT_SY_PIN_B], fall_b);
    both_b = dwt_any_edge(pin_b, st_r.prev[DWT_SY_PIN_B]);
    // both oscillators arrive as pins; only the selected one feeds the prescaler
    if (st_r.sys_sub) begin
      osc_edge = dwt_sel_edge(st_r.sy2[DWT_SY_SUB], st_r.prev[DWT_SY_SUB], 1'b0);
    end else begin
      osc_edge = dwt_sel_edge(st_r.sy2[DWT_SY_MAIN], st_r.prev[DWT_SY_MAIN], 1'b0);
    end
    tick16 = osc_edge && (st_r.pre == DWT_PRE_LAST);
  end

  // byte strobes into the two counters
  always_comb begin
    acc_a = '0;
    acc_b = '0;
    acc_a.dat = wb_req_i.dat[DWT_BYTE_W-1:0];
    acc_b.dat = wb_req_i.dat[DWT_BYTE_W-1:0];
    acc_a.wr_lo = wr && (wb_req_i.adr == DWT_OFS_A_LO);
    acc_a.wr_hi = wr && (wb_req_i.adr == DWT_OFS_A_HI);
    acc_a.rd_lo = rd && (wb_req_i.adr == DWT_OFS_A_LO);
    acc_a.rd_hi = rd && (wb_req_i.adr == DWT_OFS_A_HI);
    acc_b.wr_lo = wr && (wb_req_i.adr == DWT_OFS_B_LO);
    acc_b.wr_hi = wr && (wb_req_i.adr == DWT_OFS_B_HI);
    acc_b.rd_lo = rd && (wb_req_i.adr == DWT_OFS_B_LO);
    acc_b.rd_hi = rd && (wb_req_i.adr == DWT_OFS_B_HI);
  end

  // count enables and edge reloads per mode
  always_comb begin
    case (mode_a)
      DWT_MODE_TIMER: tick_a = tick16;
      DWT_MODE_AUX: tick_a = tick16;
      DWT_MODE_EVENT: tick_a = edge_a;
      DWT_MODE_WIDTH: tick_a = tick16 && (pin_a == ~fall_a);
      default: tick_a = 1'b0;
    endcase
    case (mode_b)
      DWT_MODE_TIMER: begin
        tick_b = tick16;
        reload_b = 1'b0;
      end
      DWT_MODE_AUX: begin
        tick_b = tick16;
        reload_b = edge_b;
      end
      DWT_MODE_EVENT: begin
        tick_b = edge_b;
        reload_b = 1'b0;
      end
      DWT_MODE_WIDTH: begin
        tick_b = tick16;
        reload_b = both_b;
      end
      default: begin
        tick_b = 1'b0;
        reload_b = 1'b0;
      end
    endcase
  end

  dwt_channel u_chan_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_a),
    .reload_i(1'b0),
    .latch_only_i(st_r.mode_a[DWT_WCTL_BIT]),
    .acc_i(acc_a),
    .hi_byte_o(a_hi),
    .lo_byte_o(a_lo),
    .underflow_o(uf_a)
  );

  // timer b has no write control bit: writes always load counter and latch
  dwt_channel u_chan_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_b),
    .reload_i(reload_b),
    .latch_only_i(1'b0),
    .acc_i(acc_b),
    .hi_byte_o(b_hi),
    .lo_byte_o(b_lo),
    .underflow_o(uf_b)
  );

  always_comb begin
    logic [DWT_IRQ_N-1:0] set;
    logic [DWT_BYTE_W-1:0] rbyte;
    set = '0;
    rbyte = '0;
    st_nxt = st_r;
    // pin and oscillator inputs: the first stage feeds only the second
    st_nxt.sy1 = {sub_osc_input_i, main_osc_input_i, wide_timer_b_pin_i, wide_timer_a_pin_i};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.prev = st_r.sy2;
    if (osc_edge) begin
      st_nxt.pre = st_r.pre + 4'h1;
    end
    set[DWT_IRQ_A_UF] = uf_a;
    set[DWT_IRQ_B_UF] = uf_b;
    set[DWT_IRQ_A_PIN] = edge_a;
    set[DWT_IRQ_B_PIN] = (mode_b == DWT_MODE_WIDTH) ? both_b : edge_b;
    if (uf_a && (mode_a == DWT_MODE_AUX)) begin
      st_nxt.pulse = ~st_r.pulse;
    end
    st_nxt.ireq = st_r.ireq | set;
    if (wr) begin
      case (wb_req_i.adr)
        DWT_OFS_A_MODE: st_nxt.mode_a = wb_req_i.dat[DWT_BYTE_W-1:0] & DWT_A_MODE_MASK;
        DWT_OFS_B_MODE: st_nxt.mode_b = wb_req_i.dat[DWT_BYTE_W-1:0] & DWT_B_MODE_MASK;
        // zero clears, one keeps; a new event in the same cycle still sets
        DWT_OFS_IREQ: st_nxt.ireq = (st_r.ireq & wb_req_i.dat[DWT_IRQ_N-1:0]) | set;
        DWT_OFS_CLKSEL: st_nxt.sys_sub = wb_req_i.dat[DWT_CLKSEL_SUB_BIT];
        default: ;
      endcase
    end
    case (wb_req_i.adr)
      DWT_OFS_A_LO: rbyte = a_lo;
      DWT_OFS_A_HI: rbyte = a_hi;
      DWT_OFS_B_LO: rbyte = b_lo;
      DWT_OFS_B_HI: rbyte = b_hi;
      DWT_OFS_A_MODE: rbyte = st_r.mode_a;
      DWT_OFS_B_MODE: rbyte = st_r.mode_b;
      DWT_OFS_IREQ: rbyte = {4'h0, st_r.ireq};
      DWT_OFS_CLKSEL: rbyte = {7'h00, st_r.sys_sub};
      default: rbyte = '0;
    endcase
    // one-wait-state slave: answer the cycle after the request is seen
    st_nxt.ack = req;
    if (rd) begin
      st_nxt.dat = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{sy1: DWT_SY_RST, sy2: DWT_SY_RST, prev: DWT_SY_RST, pre: DWT_PRE_RST,
                mode_a: DWT_MODE_RST, mode_b: DWT_MODE_RST, sys_sub: 1'b0, ireq: DWT_IRQ_RST,
                pulse: 1'b0, ack: 1'b0, dat: 32'h00000000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_rsp_o.ack = st_r.ack;
  assign wb_rsp_o.dat = st_r.dat;
  assign wide_timer_a_pin_o = st_r.pulse;
  // drives only in pulse output mode; the output enable is decoded from the timer a mode field
  assign wide_timer_a_pin_oe_n_o = (mode_a != DWT_MODE_AUX);
  assign irq_req_o = st_r.ireq;

endmodule : dwt_top
`default_nettype wire

// File: pkg/dwt_pkg.sv
// shared constants, types and bus carriers of the dual wide timer
package dwt_pkg;

  localparam int unsigned DWT_CNT_W = 16;
  localparam int unsigned DWT_BYTE_W = 8;
  localparam int unsigned DWT_ADR_W = 8;
  localparam int unsigned DWT_PRE_W = 4;

  // count source prescaler: one tick every 16 rising oscillator edges
  localparam logic [DWT_PRE_W-1:0] DWT_PRE_LAST = 4'hf;
  localparam logic [DWT_PRE_W-1:0] DWT_PRE_RST = 4'h0;

  // register byte addresses, one aligned word each, data in bits 7:0
  localparam logic [DWT_ADR_W-1:0] DWT_OFS_A_LO = 8'h00;
  localparam logic [DWT_ADR_W-1:0] DWT_OFS_A_HI = 8'h04;
  localparam logic [DWT_ADR_W-1:0] DWT_OFS_B_LO = 8'h08;
  localparam logic [DWT_ADR_W-1:0] DWT_OFS_B_HI = 8'h0c;
  localparam logic [DWT_ADR_W-1:0] DWT_OFS_A_MODE = 8'h10;
  localparam logic [DWT_ADR_W-1:0] DWT_OFS_B_MODE = 8'h14;
  localparam logic [DWT_ADR_W-1:0] DWT_OFS_IREQ = 8'h18;
  localparam logic [DWT_ADR_W-1:0] DWT_OFS_CLKSEL = 8'h1c;

  // mode register fields
  localparam int unsigned DWT_MODE_LSB = 0;
  localparam int unsigned DWT_WCTL_BIT = 2;
  localparam int unsigned DWT_EDGE_BIT = 3;
  localparam logic [DWT_BYTE_W-1:0] DWT_A_MODE_MASK = 8'h0f;
  localparam logic [DWT_BYTE_W-1:0] DWT_B_MODE_MASK = 8'h0b;
  localparam logic [DWT_BYTE_W-1:0] DWT_MODE_RST = 8'h00;

  // request register bits
  localparam int unsigned DWT_IRQ_A_UF = 0;
  localparam int unsigned DWT_IRQ_B_UF = 1;
  localparam int unsigned DWT_IRQ_A_PIN = 2;
  localparam int unsigned DWT_IRQ_B_PIN = 3;
  localparam int unsigned DWT_IRQ_N = 4;
  localparam logic [DWT_IRQ_N-1:0] DWT_IRQ_RST = 4'h0;

  localparam int unsigned DWT_CLKSEL_SUB_BIT = 0;

  // synchroniser lanes
  localparam int unsigned DWT_SY_PIN_A = 0;
  localparam int unsigned DWT_SY_PIN_B = 1;
  localparam int unsigned DWT_SY_MAIN = 2;
  localparam int unsigned DWT_SY_SUB = 3;
  localparam int unsigned DWT_SY_N = 4;
  localparam logic [DWT_SY_N-1:0] DWT_SY_RST = 4'h0;

  // aux: timer a pulse output, timer b period measurement
  // width: timer a pulse width, timer b high/low continuous
  typedef enum logic [1:0] {
    DWT_MODE_TIMER = 2'b00,
    DWT_MODE_AUX = 2'b01,
    DWT_MODE_EVENT = 2'b11,
    DWT_MODE_WIDTH = 2'b10
  } dwt_mode_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [DWT_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dwt_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } dwt_wb_rsp_s;

  typedef struct packed {
    logic wr_lo;
    logic wr_hi;
    logic rd_lo;
    logic rd_hi;
    logic [DWT_BYTE_W-1:0] dat;
  } dwt_byte_acc_s;

endpackage : dwt_pkg

// File: design/dwt_channel.sv
// one 16-bit down counter with reload latch, byte access and capture hold
`timescale 1ns/1ps
`default_nettype none
module dwt_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic reload_i,
  input wire logic latch_only_i,
  input wire dwt_pkg::dwt_byte_acc_s acc_i,
  output logic [dwt_pkg::DWT_BYTE_W-1:0] hi_byte_o,
  output logic [dwt_pkg::DWT_BYTE_W-1:0] lo_byte_o,
  output logic underflow_o
);
  import dwt_pkg::*;

  typedef struct packed {
    logic [DWT_CNT_W-1:0] cnt;
    logic [DWT_CNT_W-1:0] latch;
    logic [DWT_CNT_W-1:0] hold;
    logic hold_v;
    logic [DWT_BYTE_W-1:0] wbuf;
    logic [DWT_BYTE_W-1:0] rbuf;
  } dwt_ch_s;

  localparam logic [DWT_CNT_W-1:0] CNT_RST = 16'hffff;
  localparam logic [DWT_CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DWT_CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DWT_BYTE_W-1:0] BYTE_RST = 8'h00;

  dwt_ch_s st_r;
  dwt_ch_s st_nxt;
  logic [DWT_CNT_W-1:0] view;

  // a captured value shadows the live count until software has read it
  assign view = st_r.hold_v ? st_r.hold : st_r.cnt;
  assign hi_byte_o = view[15:8];
  assign lo_byte_o = st_r.rbuf;

  always_comb begin
    st_nxt = st_r;
    underflow_o = 1'b0;
    if (acc_i.wr_lo) begin
      st_nxt.wbuf = acc_i.dat;
    end
    if (reload_i) begin
      st_nxt.hold = st_r.cnt;
      st_nxt.hold_v = 1'b1;
      st_nxt.cnt = st_r.latch;
    end else if (tick_i) begin
      if (st_r.cnt == CNT_ZERO) begin
        underflow_o = 1'b1;
        st_nxt.cnt = st_r.latch;
      end else begin
        st_nxt.cnt = st_r.cnt - CNT_ONE;
      end
    end
    // high byte read freezes the low byte so the pair is coherent
    if (acc_i.rd_hi) begin
      st_nxt.rbuf = view[7:0];
    end
    // a fresh capture in the same cycle wins over the read release
    if (acc_i.rd_lo && !reload_i) begin
      st_nxt.hold_v = 1'b0;
    end
    // low byte waits in a buffer; the high byte commits the word
    if (acc_i.wr_hi) begin
      st_nxt.latch = {acc_i.dat, st_r.wbuf};
      if (!latch_only_i) begin
        st_nxt.cnt = {acc_i.dat, st_r.wbuf};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{cnt: CNT_RST, latch: CNT_RST, hold: CNT_ZERO, hold_v: 1'b0, wbuf: BYTE_RST, rbuf: BYTE_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : dwt_channel
`default_nettype wire

// File: tb/dwt_top_sva.sv
// port assertions of the dual wide timer
`timescale 1ns/1ps
`default_nettype none
module dwt_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dwt_pkg::dwt_wb_req_s wb_req_i,
  input wire dwt_pkg::dwt_wb_rsp_s wb_rsp_o,
  input wire logic wide_timer_a_pin_i,
  input wire logic wide_timer_a_pin_o,
  input wire logic wide_timer_a_pin_oe_n_o,
  input wire logic wide_timer_b_pin_i,
  input wire logic [dwt_pkg::DWT_IRQ_N-1:0] irq_req_o
);
  import dwt_pkg::*;
  logic take, clr_wr, a_q_r, b_q_r;
  logic [3:0] age_a_r, age_b_r;
  assign take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign clr_wr = take && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == DWT_OFS_IREQ;
  // cycles since a pin last moved; bounds the synchroniser and edge detector delay
  always_ff @(posedge clk_i) begin
    a_q_r <= wide_timer_a_pin_i;
    b_q_r <= wide_timer_b_pin_i;
    age_a_r <= rst_i ? 4'hf : (a_q_r != wide_timer_a_pin_i) ? 4'h0 : age_a_r + {3'h0, age_a_r != 4'hf};
    age_b_r <= rst_i ? 4'hf : (b_q_r != wide_timer_b_pin_i) ? 4'h0 : age_b_r + {3'h0, age_b_r != 4'hf};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_wait: assert property (take |=> wb_rsp_o.ack)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held too long");
  chk_unmapped_zero: assert property (take && !wb_req_i.we && wb_req_i.adr > DWT_OFS_CLKSEL |=> wb_rsp_o.dat == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_clear_only: assert property (
    |($past(irq_req_o) & ~irq_req_o) |-> $past(clr_wr) || $past(rst_i))
    else $error("request bit dropped without a write");
  chk_pulse_oe: assert property (
    $changed(wide_timer_a_pin_o) && !$past(rst_i) |-> !wide_timer_a_pin_oe_n_o)
    else $error("pin toggled while not driven");
  chk_pulse_uf: assert property (
    $changed(wide_timer_a_pin_o) && !$past(rst_i) |-> irq_req_o[DWT_IRQ_A_UF])
    else $error("pin toggled without underflow");
  chk_a_edge_src: assert property (
    $rose(irq_req_o[DWT_IRQ_A_PIN]) |-> age_a_r < 4'h8)
    else $error("timer a pin request without edge");
  chk_b_edge_src: assert property (
    $rose(irq_req_o[DWT_IRQ_B_PIN]) |-> age_b_r < 4'h8)
    else $error("timer b pin request without edge");
endmodule : dwt_top_sva
bind dwt_top dwt_top_sva i_dwt_top_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .wide_timer_a_pin_i(wide_timer_a_pin_i), .wide_timer_a_pin_o(wide_timer_a_pin_o),
  .wide_timer_a_pin_oe_n_o(wide_timer_a_pin_oe_n_o), .wide_timer_b_pin_i(wide_timer_b_pin_i), .irq_req_o(irq_req_o));
`default_nettype wire

// File: tb/dwt_pin_model.sv
// pin side model: oscillators and pulse sources at the timer pins
`timescale 1ns/1ps
`default_nettype none
module dwt_pin_model (
  input wire logic clk_i,
  input wire logic main_en_i,
  input wire logic a_src_i,
  input wire logic b_src_i,
  input wire logic a_out_i,
  input wire logic a_oe_n_i,
  output logic main_osc_o,
  output logic sub_osc_o,
  output logic a_pin_o,
  output logic b_pin_o
);
  logic [2:0] div_r = 3'h0;
  always @(posedge clk_i) div_r <= div_r + 3'h1;
  // a stopped main oscillator rests low
  assign main_osc_o = div_r[1] & main_en_i;
  assign sub_osc_o = div_r[2];
  assign a_pin_o = a_oe_n_i ? a_src_i : a_out_i;
  assign b_pin_o = b_src_i;
endmodule : dwt_pin_model
`default_nettype wire

// File: tb/dwt_top_bench.sv
// self-checking bench of the dual wide timer
`timescale 1ns/1ps
`default_nettype none
module dwt_top_bench;
  import dwt_pkg::*;
  logic clk_i, rst_i, main_en, a_src, b_src, main_osc, sub_osc, a_pin, b_pin, a_out, a_oe_n, p;
  logic [3:0] irq;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  dwt_wb_req_s wb_req;
  dwt_wb_rsp_s wb_rsp;
  int fail_count = 0, comparisons = 0, cycles = 0, seed = 40570;
  dwt_top i_dwt_top (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .main_osc_input_i(main_osc),
    .sub_osc_input_i(sub_osc), .wide_timer_a_pin_i(a_pin), .wide_timer_a_pin_o(a_out),
    .wide_timer_a_pin_oe_n_o(a_oe_n), .wide_timer_b_pin_i(b_pin), .irq_req_o(irq));
  dwt_pin_model i_dwt_pin_model (.clk_i(clk_i), .main_en_i(main_en), .a_src_i(a_src), .b_src_i(b_src),
    .a_out_i(a_out), .a_oe_n_i(a_oe_n), .main_osc_o(main_osc), .sub_osc_o(sub_osc), .a_pin_o(a_pin), .b_pin_o(b_pin));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic hold(input int c);
    repeat (c) @(posedge clk_i);
  endtask : hold
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: {r[3:1], 1'b1}, dat: {r[31:8], d}};
    do @(posedge clk_i); while (wb_rsp.ack !== 1'b1);
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  // the note goes in before the request so the monitor finds it at ack
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    exp_q.push_back({m, x});
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, v[15:8]);
  endtask : wr16
  task automatic rd16(input logic [7:0] a, input logic [15:0] x, input logic [15:0] m);
    rd(a + 8'h04, x[15:8], m[15:8]);
    rd(a, x[7:0], m[7:0]);
  endtask : rd16
  task automatic wait_irq(input int b);
    for (int n = 0; n < 3000 && irq[b] !== 1'b1; n++) @(negedge clk_i);
    // a wait that runs dry is a mismatch, not a silent pass
    check({31'h0, irq[b]}, 32'h1);
  endtask : wait_irq
  task automatic pulse(input logic [1:0] s);
    repeat (2) begin
      {b_src, a_src} <= s;
      hold(4);
      {b_src, a_src} <= 2'b00;
      hold(4);
    end
  endtask : pulse
  always @(posedge clk_i) begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(wb_rsp.dat & {24'hffffff, e[15:8]}, {24'h0, e[7:0] & e[15:8]});
    end
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    wb_req = '0;
    rst_i = 1'b1;
    main_en = 1'b1;
    a_src = 1'b0;
    b_src = 1'b0;
    hold(3);
    rst_i <= 1'b0;
    rd16(DWT_OFS_A_LO, 16'hffff, 16'hffff);
    rd(DWT_OFS_A_MODE, 8'h00, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    wr16(DWT_OFS_A_LO, 16'h0002);
    rd16(DWT_OFS_A_LO, 16'h0000, 16'hfffc);
    wait_irq(DWT_IRQ_A_UF);
    rd(DWT_OFS_IREQ, 8'h01, 8'h01);
    wr(DWT_OFS_A_MODE, 8'h04);
    wr16(DWT_OFS_A_LO, 16'h1234);
    rd16(DWT_OFS_A_LO, 16'h0000, 16'hfffc);
    wr(DWT_OFS_IREQ, 8'h00);
    wait_irq(DWT_IRQ_A_UF);
    rd16(DWT_OFS_A_LO, 16'h1200, 16'hff00);
    wr(DWT_OFS_IREQ, 8'hff);
    rd(DWT_OFS_IREQ, 8'h01, 8'h01);
    wr(DWT_OFS_IREQ, 8'h00);
    rd(DWT_OFS_IREQ, 8'h00, 8'h0f);
    $display("end write control");
    main_en <= 1'b0;
    wr(DWT_OFS_CLKSEL, 8'h01);
    wr(DWT_OFS_A_MODE, 8'h00);
    wr16(DWT_OFS_A_LO, 16'h0001);
    wr(DWT_OFS_IREQ, 8'h00);
    wait_irq(DWT_IRQ_A_UF);
    rd(DWT_OFS_IREQ, 8'h01, 8'h0f);
    main_en <= 1'b1;
    wr(DWT_OFS_CLKSEL, 8'h00);
    wr(DWT_OFS_A_MODE, 8'h01);
    wr(DWT_OFS_IREQ, 8'h00);
    // take the level right after an underflow so no toggle can slip in before the next wait
    wait_irq(DWT_IRQ_A_UF);
    @(negedge clk_i);
    p = a_pin;
    wr(DWT_OFS_IREQ, 8'h00);
    wait_irq(DWT_IRQ_A_UF);
    check({31'h0, a_pin}, {31'h0, ~p});
    check({31'h0, a_oe_n}, 32'h0);
    wr(DWT_OFS_A_MODE, 8'h03);
    wr16(DWT_OFS_A_LO, 16'h0001);
    wr(DWT_OFS_IREQ, 8'h00);
    pulse(2'b01);
    rd(DWT_OFS_IREQ, 8'h05, 8'h0f);
    wr(DWT_OFS_A_MODE, 8'h02);
    wr16(DWT_OFS_A_LO, 16'h1000);
    hold(300);
    rd16(DWT_OFS_A_LO, 16'h1000, 16'hffff);
    wr(DWT_OFS_A_MODE, 8'h0a);
    hold(300);
    rd16(DWT_OFS_A_LO, 16'h0f00, 16'hff00);
    $display("end timer a modes");
    wr(DWT_OFS_B_MODE, 8'h01);
    wr16(DWT_OFS_B_LO, 16'h0105);
    wr(DWT_OFS_IREQ, 8'h00);
    hold(600);
    b_src <= 1'b1;
    hold(8);
    rd(DWT_OFS_IREQ, 8'h08, 8'h08);
    rd16(DWT_OFS_B_LO, 16'h0000, 16'hff00);
    rd16(DWT_OFS_B_LO, 16'h0100, 16'hff00);
    wr(DWT_OFS_B_MODE, 8'h02);
    wr(DWT_OFS_IREQ, 8'h00);
    b_src <= 1'b0;
    hold(8);
    rd(DWT_OFS_IREQ, 8'h08, 8'h08);
    wr(DWT_OFS_B_MODE, 8'h08);
    wr(DWT_OFS_IREQ, 8'h00);
    b_src <= 1'b1;
    hold(8);
    rd(DWT_OFS_IREQ, 8'h00, 8'h08);
    b_src <= 1'b0;
    hold(8);
    rd(DWT_OFS_IREQ, 8'h08, 8'h08);
    wr(DWT_OFS_B_MODE, 8'h07);
    rd(DWT_OFS_B_MODE, 8'h03, 8'hff);
    wr16(DWT_OFS_B_LO, 16'h0001);
    wr(DWT_OFS_IREQ, 8'h00);
    pulse(2'b10);
    rd(DWT_OFS_IREQ, 8'h0a, 8'h0a);
    $display("end timer b modes");
    complete_run();
  end
endmodule : dwt_top_bench
`default_nettype wire
